// ---- design/irq_unit_pkg.sv ----
package irq_unit_pkg;

  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_GROUP_FLAGS = 8'h3B;
  localparam logic [7:0] OFS_PIN_FLAGS   = 8'h3C;
  localparam logic [7:0] OFS_PIN_ENABLE  = 8'h3D;
  localparam logic [7:0] OFS_GROUP_CTRL  = 8'h68;
  localparam logic [7:0] OFS_SENSE_CTRL  = 8'h69;
  localparam logic [7:0] OFS_GROUP0_MASK = 8'h6B;
  localparam logic [7:0] OFS_GROUP1_MASK = 8'h6C;
  localparam logic [7:0] OFS_GROUP2_MASK = 8'h6D;

  // ------------------------------------------------------------
  // Sizes, field positions, reset values
  // ------------------------------------------------------------
  localparam int NUM_PINS        = 2;
  localparam int NUM_GROUPS      = 3;
  localparam int NUM_SOURCES     = 5;
  localparam int GROUP_WIDTH     = 8;
  localparam int NUM_CHANGE_PINS = 24;
  localparam int SENSE_FIELD_W   = 2;
  localparam int SENSE_PIN0_LSB  = 0;
  localparam int SENSE_PIN1_LSB  = 2;
  localparam int SENSE_CTRL_W    = 4;
  localparam int SYNC_FILL_CYCLES = 3;

  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [3:0] SENSE_RESET = 4'h0;
  localparam logic [1:0] ENABLE_RESET = 2'h0;
  localparam logic [2:0] GROUP_CTRL_RESET = 3'h0;

  // Implemented mask bits per group; group 1 has seven pins
  localparam logic [7:0] GROUP0_MASK_USED = 8'hFF;
  localparam logic [7:0] GROUP1_MASK_USED = 8'h7F;
  localparam logic [7:0] GROUP2_MASK_USED = 8'hFF;

  // ------------------------------------------------------------
  // Vector numbering of the request lines
  // ------------------------------------------------------------
  localparam int VEC_PIN0   = 0;
  localparam int VEC_PIN1   = 1;
  localparam int VEC_GROUP0 = 2;
  localparam int VEC_GROUP1 = 3;
  localparam int VEC_GROUP2 = 4;

  typedef enum logic [1:0] {
    SENSE_LOW  = 2'h0,
    SENSE_ANY  = 2'h1,
    SENSE_FALL = 2'h2,
    SENSE_RISE = 2'h3
  } sense_mode_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

endpackage

// ---- design/pin_sync_edge.sv ----
`timescale 1ns/1ps
module pin_sync_edge #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  // Pins and detected events
  input  wire logic [WIDTH-1:0] pins_in,
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] fall,
  output logic      [WIDTH-1:0] change
);

  logic [WIDTH-1:0] stage1_q, stage1_d;
  logic [WIDTH-1:0] stage2_q, stage2_d;
  logic [WIDTH-1:0] prev_q,   prev_d;
  logic [irq_unit_pkg::SYNC_FILL_CYCLES-1:0] fill_q, fill_d;
  logic             primed;

  always_comb begin
    stage1_d = pins_in;
    stage2_d = stage1_q;
    prev_d   = stage2_q;
    fill_d   = {fill_q[irq_unit_pkg::SYNC_FILL_CYCLES-2:0], 1'b1};
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1_q <= '0;
      stage2_q <= '0;
      prev_q   <= '0;
      fill_q   <= '0;
    end else begin
      stage1_q <= stage1_d;
      stage2_q <= stage2_d;
      prev_q   <= prev_d;
      fill_q   <= fill_d;
    end
  end

  // ------------------------------------------------------------
  // Edges on sampled values, held off until the chain is filled
  // ------------------------------------------------------------
  assign primed = fill_q[irq_unit_pkg::SYNC_FILL_CYCLES-1];
  assign level  = stage2_q;
  assign rise   = primed ? (stage2_q & ~prev_q) : '0;
  assign fall   = primed ? (~stage2_q & prev_q) : '0;
  assign change = primed ? (stage2_q ^ prev_q) : '0;

  AST_PULSE_SEEN: assert property (@(posedge core_clk) disable iff (!rst_n)
    (primed && !pins_in[0]) ##1 (pins_in[0] [*2]) |-> ##[1:3] rise[0])
    else $error("Two-cycle high pulse gave no rising edge");

endmodule

// ---- design/irq_flag_cell.sv ----
`timescale 1ns/1ps
module irq_flag_cell (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // Control
  input  wire logic set,
  input  wire logic clear,
  input  wire logic hold_clear,
  // State
  output logic      flag
);

  logic flag_q, flag_d;

  always_comb begin
    if (hold_clear) begin
      flag_d = 1'b0;
    end else if (set) begin
      flag_d = 1'b1;
    end else if (clear) begin
      flag_d = 1'b0;
    end else begin
      flag_d = flag_q;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign flag = flag_q;

  AST_SET_BEATS_CLEAR: assert property (@(posedge core_clk) disable iff (!rst_n)
    (set && clear && !hold_clear) |=> flag)
    else $error("Clear won over a set in the same cycle");

  AST_HOLD_KEEPS_ZERO: assert property (@(posedge core_clk) disable iff (!rst_n)
    hold_clear [*2] |-> !flag)
    else $error("Flag set while held clear");

  AST_FLAG_STICKY: assert property (@(posedge core_clk) disable iff (!rst_n)
    (flag && !clear && !hold_clear) |=> flag)
    else $error("Flag dropped without a clear");

endmodule

// ---- design/external_pin_irq_unit.sv ----
`timescale 1ns/1ps
module external_pin_irq_unit (
  // Clock and reset
  input  wire logic                    core_clk,
  input  wire logic                    nrst,
  // Register port
  input  wire irq_unit_pkg::reg_req_t  bus_req,
  output logic                  [7:0]  rd_data,
  output logic                         rd_valid,
  // External pins
  input  wire logic             [1:0]  dedicated_irq_pin,
  input  wire logic             [23:0] change_sense_pin,
  // Core side
  input  wire logic                    global_irq_enable,
  input  wire logic             [4:0]  vector_ack,
  output logic                  [4:0]  irq_request,
  output logic                         wake_request
);

  // ------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------
  logic rst_meta_q;
  logic rst_n;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  // ------------------------------------------------------------
  // Register file
  // ------------------------------------------------------------
  logic [irq_unit_pkg::SENSE_CTRL_W-1:0] sense_q,      sense_d;
  logic [irq_unit_pkg::NUM_PINS-1:0]     enable_q,     enable_d;
  logic [irq_unit_pkg::NUM_GROUPS-1:0]   group_ctrl_q, group_ctrl_d;
  logic [irq_unit_pkg::GROUP_WIDTH-1:0]  mask_q [irq_unit_pkg::NUM_GROUPS];
  logic [irq_unit_pkg::GROUP_WIDTH-1:0]  mask_d [irq_unit_pkg::NUM_GROUPS];
  logic [7:0]                            rd_data_q,    rd_data_d;
  logic                                  rd_valid_q,   rd_valid_d;
  logic [irq_unit_pkg::NUM_SOURCES-1:0]  src_flag;
  logic [irq_unit_pkg::NUM_SOURCES-1:0]  src_set;
  logic [irq_unit_pkg::NUM_SOURCES-1:0]  src_clr;
  logic [irq_unit_pkg::NUM_SOURCES-1:0]  src_hold;
  logic [irq_unit_pkg::GROUP_WIDTH-1:0]  mask_used [irq_unit_pkg::NUM_GROUPS];
  logic                                  wr_pin_flags;
  logic                                  wr_group_flags;

  assign mask_used[0] = irq_unit_pkg::GROUP0_MASK_USED;
  assign mask_used[1] = irq_unit_pkg::GROUP1_MASK_USED;
  assign mask_used[2] = irq_unit_pkg::GROUP2_MASK_USED;

  always_comb begin
    sense_d      = sense_q;
    enable_d     = enable_q;
    group_ctrl_d = group_ctrl_q;
    for (int g = 0; g < irq_unit_pkg::NUM_GROUPS; g++) begin
      mask_d[g] = mask_q[g];
    end
    rd_data_d  = irq_unit_pkg::RESET_BYTE;
    rd_valid_d = bus_req.rd;
    if (bus_req.wr) begin
      case (bus_req.addr)
        irq_unit_pkg::OFS_SENSE_CTRL:  sense_d      = bus_req.wdata[3:0];
        irq_unit_pkg::OFS_PIN_ENABLE:  enable_d     = bus_req.wdata[1:0];
        irq_unit_pkg::OFS_GROUP_CTRL:  group_ctrl_d = bus_req.wdata[2:0];
        irq_unit_pkg::OFS_GROUP0_MASK: mask_d[0]    = bus_req.wdata & mask_used[0];
        irq_unit_pkg::OFS_GROUP1_MASK: mask_d[1]    = bus_req.wdata & mask_used[1];
        irq_unit_pkg::OFS_GROUP2_MASK: mask_d[2]    = bus_req.wdata & mask_used[2];
        default: ;
      endcase
    end
    if (bus_req.rd) begin
      case (bus_req.addr)
        irq_unit_pkg::OFS_SENSE_CTRL:  rd_data_d = {4'h0, sense_q};
        irq_unit_pkg::OFS_PIN_ENABLE:  rd_data_d = {6'h00, enable_q};
        irq_unit_pkg::OFS_GROUP_CTRL:  rd_data_d = {5'h00, group_ctrl_q};
        irq_unit_pkg::OFS_PIN_FLAGS:   rd_data_d = {6'h00, src_flag[1:0]};
        irq_unit_pkg::OFS_GROUP_FLAGS: rd_data_d = {5'h00, src_flag[4:2]};
        irq_unit_pkg::OFS_GROUP0_MASK: rd_data_d = mask_q[0];
        irq_unit_pkg::OFS_GROUP1_MASK: rd_data_d = mask_q[1];
        irq_unit_pkg::OFS_GROUP2_MASK: rd_data_d = mask_q[2];
        default:                       rd_data_d = irq_unit_pkg::RESET_BYTE;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sense_q      <= irq_unit_pkg::SENSE_RESET;
      enable_q     <= irq_unit_pkg::ENABLE_RESET;
      group_ctrl_q <= irq_unit_pkg::GROUP_CTRL_RESET;
      for (int g = 0; g < irq_unit_pkg::NUM_GROUPS; g++) begin
        mask_q[g] <= irq_unit_pkg::RESET_BYTE;
      end
      rd_data_q  <= irq_unit_pkg::RESET_BYTE;
      rd_valid_q <= 1'b0;
    end else begin
      sense_q      <= sense_d;
      enable_q     <= enable_d;
      group_ctrl_q <= group_ctrl_d;
      for (int g = 0; g < irq_unit_pkg::NUM_GROUPS; g++) begin
        mask_q[g] <= mask_d[g];
      end
      rd_data_q  <= rd_data_d;
      rd_valid_q <= rd_valid_d;
    end
  end

  assign rd_data  = rd_data_q;
  assign rd_valid = rd_valid_q;

  assign wr_pin_flags   = bus_req.wr && (bus_req.addr == irq_unit_pkg::OFS_PIN_FLAGS);
  assign wr_group_flags = bus_req.wr && (bus_req.addr == irq_unit_pkg::OFS_GROUP_FLAGS);

  // ------------------------------------------------------------
  // Pin sampling
  // ------------------------------------------------------------
  logic [1:0]  pin_level, pin_rise, pin_fall, pin_change;
  logic [23:0] chg_level, chg_change;

  // Pin value is taken as is, whatever the port direction
  pin_sync_edge #(.WIDTH(irq_unit_pkg::NUM_PINS)) u_pin_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .pins_in  (dedicated_irq_pin),
    .level    (pin_level),
    .rise     (pin_rise),
    .fall     (pin_fall),
    .change   (pin_change)
  );

  pin_sync_edge #(.WIDTH(irq_unit_pkg::NUM_CHANGE_PINS)) u_chg_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .pins_in  (change_sense_pin),
    .level    (chg_level),
    .rise     (),
    .fall     (),
    .change   (chg_change)
  );

  // ------------------------------------------------------------
  // Dedicated pins
  // ------------------------------------------------------------
  irq_unit_pkg::sense_mode_t pin_mode [irq_unit_pkg::NUM_PINS];
  logic [1:0] pin_low_mode;
  logic [1:0] pin_level_req;

  for (genvar p = 0; p < irq_unit_pkg::NUM_PINS; p++) begin : g_pin
    assign pin_mode[p] = irq_unit_pkg::sense_mode_t'(
      sense_q[p*irq_unit_pkg::SENSE_FIELD_W +: irq_unit_pkg::SENSE_FIELD_W]);
    assign pin_low_mode[p] = (pin_mode[p] == irq_unit_pkg::SENSE_LOW);
    always_comb begin
      unique case (pin_mode[p])
        irq_unit_pkg::SENSE_LOW:  src_set[p] = 1'b0;
        irq_unit_pkg::SENSE_ANY:  src_set[p] = pin_change[p];
        irq_unit_pkg::SENSE_FALL: src_set[p] = pin_fall[p];
        irq_unit_pkg::SENSE_RISE: src_set[p] = pin_rise[p];
      endcase
    end
    assign src_hold[p]      = pin_low_mode[p];
    assign src_clr[p]       = (wr_pin_flags && bus_req.wdata[p])
                              || vector_ack[irq_unit_pkg::VEC_PIN0 + p];
    assign pin_level_req[p] = pin_low_mode[p] && !pin_level[p];
    assign irq_request[irq_unit_pkg::VEC_PIN0 + p] = enable_q[p] && global_irq_enable
      && (pin_low_mode[p] ? pin_level_req[p] : src_flag[p]);
  end

  // ------------------------------------------------------------
  // Pin-change groups
  // ------------------------------------------------------------
  for (genvar g = 0; g < irq_unit_pkg::NUM_GROUPS; g++) begin : g_group
    localparam int V = irq_unit_pkg::VEC_GROUP0 + g;
    assign src_set[V]  = |(chg_change[g*irq_unit_pkg::GROUP_WIDTH +: irq_unit_pkg::GROUP_WIDTH]
                           & mask_q[g]);
    assign src_hold[V] = 1'b0;
    assign src_clr[V]  = (wr_group_flags && bus_req.wdata[g]) || vector_ack[V];
    assign irq_request[V] = group_ctrl_q[g] && global_irq_enable
                            && src_flag[V];
  end

  for (genvar s = 0; s < irq_unit_pkg::NUM_SOURCES; s++) begin : g_flag
    irq_flag_cell u_flag (
      .core_clk   (core_clk),
      .rst_n      (rst_n),
      .set        (src_set[s]),
      .clear      (src_clr[s]),
      .hold_clear (src_hold[s]),
      .flag       (src_flag[s])
    );
  end

  // ------------------------------------------------------------
  // Clockless wake paths, straight from the pins
  // ------------------------------------------------------------
  logic [1:0]  wake_low;
  logic [23:0] wake_chg_en;

  for (genvar g = 0; g < irq_unit_pkg::NUM_GROUPS; g++) begin : g_wake
    assign wake_chg_en[g*irq_unit_pkg::GROUP_WIDTH +: irq_unit_pkg::GROUP_WIDTH] =
      group_ctrl_q[g] ? mask_q[g] : 8'h00;
  end

  assign wake_low     = enable_q & pin_low_mode & ~dedicated_irq_pin;
  assign wake_request = (|wake_low)
                        || (|((change_sense_pin ^ chg_level) & wake_chg_en));

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  AST_RISE_SETS_FLAG: assert property (@(posedge core_clk) disable iff (!rst_n)
    (pin_mode[0] == irq_unit_pkg::SENSE_RISE && pin_rise[0]) |=> src_flag[0])
    else $error("Rising edge did not set pin 0 flag");

  AST_FALL_IGNORES_RISE: assert property (@(posedge core_clk) disable iff (!rst_n)
    (pin_mode[1] == irq_unit_pkg::SENSE_FALL && !src_flag[1] && !pin_fall[1])
    |=> !src_flag[1])
    else $error("Pin 1 flag set without a falling edge");

  AST_LOW_MODE_NO_FLAG: assert property (@(posedge core_clk) disable iff (!rst_n)
    pin_low_mode[0] |=> !src_flag[0])
    else $error("Pin 0 flag set in low-level mode");

  AST_LOW_LEVEL_REQ: assert property (@(posedge core_clk) disable iff (!rst_n)
    pin_low_mode[1] |-> (irq_request[irq_unit_pkg::VEC_PIN1]
      == (enable_q[1] && global_irq_enable && !pin_level[1])))
    else $error("Pin 1 level request wrong");

  AST_GLOBAL_GATE: assert property (@(posedge core_clk) disable iff (!rst_n)
    !global_irq_enable |-> (irq_request == 5'h00))
    else $error("Request raised with global enable clear");

  AST_WRITE_ONE_CLEARS: assert property (@(posedge core_clk) disable iff (!rst_n)
    (wr_pin_flags && bus_req.wdata[0] && !src_set[0]) |=> !src_flag[0])
    else $error("Write of one did not clear pin 0 flag");

  AST_WRITE_ZERO_KEEPS: assert property (@(posedge core_clk) disable iff (!rst_n)
    (wr_pin_flags && !bus_req.wdata[1] && src_flag[1] && !pin_low_mode[1]
     && !vector_ack[irq_unit_pkg::VEC_PIN1]) |=> src_flag[1])
    else $error("Write of zero cleared pin 1 flag");

  AST_GROUP_CHANGE_SETS: assert property (@(posedge core_clk) disable iff (!rst_n)
    (|(chg_change[23:16] & mask_q[2])) |=> src_flag[irq_unit_pkg::VEC_GROUP2])
    else $error("Enabled change did not set group 2 flag");

  AST_GROUP_REQ: assert property (@(posedge core_clk) disable iff (!rst_n)
    (src_flag[irq_unit_pkg::VEC_GROUP0] && group_ctrl_q[0] && global_irq_enable)
    |-> irq_request[irq_unit_pkg::VEC_GROUP0])
    else $error("Group 0 request missing");

  AST_ENABLE_READBACK: assert property (@(posedge core_clk) disable iff (!rst_n)
    (bus_req.rd && bus_req.addr == irq_unit_pkg::OFS_PIN_ENABLE)
    |=> (rd_valid && rd_data == {6'h00, $past(enable_q)}))
    else $error("Enable register read back wrong");

  AST_ACK_CLEARS: assert property (@(posedge core_clk) disable iff (!rst_n)
    (vector_ack[irq_unit_pkg::VEC_PIN0] && !src_set[0]) |=> !src_flag[0])
    else $error("Vector entry did not clear pin 0 flag");

  AST_MASKED_NO_SET: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!src_flag[irq_unit_pkg::VEC_GROUP1] && !(|(chg_change[15:8] & mask_q[1])))
    |=> !src_flag[irq_unit_pkg::VEC_GROUP1])
    else $error("Group 1 flag set without an enabled change");

  AST_GROUP_GATE: assert property (@(posedge core_clk) disable iff (!rst_n)
    !group_ctrl_q[2] |-> !irq_request[irq_unit_pkg::VEC_GROUP2])
    else $error("Group 2 request raised while disabled");

  AST_PIN_ENABLE_GATE: assert property (@(posedge core_clk) disable iff (!rst_n)
    !enable_q[0] |-> !irq_request[irq_unit_pkg::VEC_PIN0])
    else $error("Pin 0 request raised while disabled");

endmodule

// ---- dv/board_pin_model.sv ----
`timescale 1ns/1ps
module board_pin_model (
  // Clock
  input  wire logic        core_clk,
  // Levels asked for by the bench
  input  wire logic [1:0]  ded_target,
  input  wire logic [23:0] chg_target,
  input  wire logic [1:0]  hold_low,
  // Core side
  input  wire logic [4:0]  vector_ack,
  // Pins
  output logic      [1:0]  dedicated_irq_pin,
  output logic      [23:0] change_sense_pin
);
  // ------------------------------------------------------------
  // Pin drive
  // ------------------------------------------------------------
  logic [1:0]  phase = 2'h0;
  logic [1:0]  held  = 2'h0;
  logic [1:0]  dq    = 2'h0;
  logic [23:0] cq    = 24'h0;

  initial begin
    dedicated_irq_pin = 2'h0;
    change_sense_pin  = 24'h0;
  end

  // Levels change at most every third cycle
  always @(posedge core_clk) begin
    phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
    dq    <= ded_target;
    cq    <= chg_target;
    // Low level kept until the core takes the request
    held  <= ~vector_ack[1:0] & (held | (hold_low & ~dedicated_irq_pin));
  end

  always @(negedge core_clk) begin
    if (phase == 2'h0) begin
      change_sense_pin  <= cq;
      dedicated_irq_pin <= dq & ~held;
    end
  end
endmodule

// ---- dv/external_pin_irq_unit_tb_top.sv ----
`timescale 1ns/1ps
module external_pin_irq_unit_tb_top;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic                   core_clk = 1'b0;
  logic                   nrst = 1'b0;
  irq_unit_pkg::reg_req_t bus_req = '0;
  logic [7:0]             rd_data;
  logic                   rd_valid;
  logic [1:0]             dedicated_irq_pin;
  logic [23:0]            change_sense_pin;
  logic                   global_irq_enable = 1'b0;
  logic [4:0]             vector_ack = 5'h00;
  logic [4:0]             irq_request;
  logic                   wake_request;
  logic [1:0]             ded_target = 2'h0;
  logic [23:0]            chg_target = 24'h0;
  logic [1:0]             hold_low = 2'h0;
  int                     err_count = 0;
  int                     tests_run = 0;
  int                     seed = 32'hdaa7;
  logic [7:0]             rdv, wv, en;
  logic [7:0]             msk [3];
  logic [2:0]             gexp;
  logic [1:0]             m;
  logic                   old, f;
  logic [23:0]            oldc;
  logic [7:0]             ofs [9] = '{8'h3B, 8'h3C, 8'h3D, 8'h68, 8'h69, 8'h6B, 8'h6C, 8'h6D, 8'h50};
  logic [7:0]             wofs [6] = '{8'h3D, 8'h68, 8'h69, 8'h6B, 8'h6C, 8'h6D};
  logic [7:0]             wexp [6] = '{8'h03, 8'h07, 8'h0F, 8'hFF, 8'h7F, 8'hFF};

  always #4 core_clk = ~core_clk;

  external_pin_irq_unit external_pin_irq_unit_i (
    .core_clk(core_clk), .nrst(nrst), .bus_req(bus_req), .rd_data(rd_data),
    .rd_valid(rd_valid), .dedicated_irq_pin(dedicated_irq_pin),
    .change_sense_pin(change_sense_pin), .global_irq_enable(global_irq_enable),
    .vector_ack(vector_ack), .irq_request(irq_request), .wake_request(wake_request));

  board_pin_model board_pin_model_i (
    .core_clk(core_clk), .ded_target(ded_target), .chg_target(chg_target),
    .hold_low(hold_low), .vector_ack(vector_ack),
    .dedicated_irq_pin(dedicated_irq_pin), .change_sense_pin(change_sense_pin));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic trig(input logic [1:0] md, input logic o, input logic n);
    case (md)
      2'h1: return o ^ n;
      2'h2: return o & ~n;
      2'h3: return ~o & n;
      default: return 1'b0;
    endcase
  endfunction

  function automatic logic [2:0] grp(input logic [23:0] d);
    logic [23:0] used;
    used = {irq_unit_pkg::GROUP2_MASK_USED, irq_unit_pkg::GROUP1_MASK_USED,
            irq_unit_pkg::GROUP0_MASK_USED};
    for (int g = 0; g < 3; g++) grp[g] = |(d[g*8 +: 8] & msk[g] & used[g*8 +: 8]);
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    bus_req.wr = 1'b1;
    bus_req.addr = a;
    bus_req.wdata = d;
    @(negedge core_clk);
    bus_req.wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk);
    bus_req.rd = 1'b1;
    bus_req.addr = a;
    @(negedge core_clk);
    bus_req.rd = 1'b0;
    d = rd_data;
    chk(8'(rd_valid), 8'h01);
  endtask

  task automatic ack(input logic [4:0] v);
    @(negedge core_clk);
    vector_ack = v;
    @(negedge core_clk);
    vector_ack = 5'h00;
  endtask

  task automatic settle;
    repeat (10) @(negedge core_clk);
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    stop_test();
  end

  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    repeat (3) @(negedge core_clk);
    nrst = 1'b1;
    repeat (8) @(negedge core_clk);
    foreach (ofs[i]) begin
      rd(ofs[i], rdv);
      chk(rdv, 8'h00);
    end
    foreach (wofs[i]) begin
      wr(wofs[i], 8'hFF);
      rd(wofs[i], rdv);
      chk(rdv, wexp[i]);
      wr(wofs[i], 8'h00);
    end
    // Edge and change modes on both dedicated pins
    wr(irq_unit_pkg::OFS_PIN_ENABLE, 8'h03);
    for (int p = 0; p < 2; p++) begin
      for (int mm = 1; mm < 4; mm++) begin
        m = mm[1:0];
        wr(irq_unit_pkg::OFS_SENSE_CTRL, 8'(m) << (2 * p));
        wr(irq_unit_pkg::OFS_PIN_FLAGS, 8'h03);
        repeat (6) begin
          old = ded_target[p];
          ded_target[p] = 1'($random(seed));
          global_irq_enable = 1'($random(seed));
          settle();
          f = trig(m, old, ded_target[p]);
          rd(irq_unit_pkg::OFS_PIN_FLAGS, rdv);
          chk(rdv[p], f);
          chk(irq_request[p], f & global_irq_enable);
          wv = 8'($random(seed));
          wr(irq_unit_pkg::OFS_PIN_FLAGS, wv);
          rd(irq_unit_pkg::OFS_PIN_FLAGS, rdv);
          chk(rdv[p], f & ~wv[p]);
          ack(5'(1 << p));
          rd(irq_unit_pkg::OFS_PIN_FLAGS, rdv);
          chk(rdv[p], 1'b0);
        end
      end
    end
    // Low-level mode on pin 0
    wr(irq_unit_pkg::OFS_SENSE_CTRL, 8'h00);
    global_irq_enable = 1'b1;
    ded_target[0] = 1'b0;
    ded_target[1] = 1'b1;
    hold_low = 2'h1;
    settle();
    ded_target[0] = 1'b1;
    hold_low = 2'h0;
    settle();
    rd(irq_unit_pkg::OFS_PIN_FLAGS, rdv);
    chk(rdv[0], 1'b0);
    chk(irq_request[0], 1'b1);
    chk(wake_request, 1'b1);
    ack(5'h01);
    settle();
    chk(irq_request[0], 1'b0);
    chk(wake_request, 1'b0);
    // Pin-change groups
    for (int i = 0; i < 24; i++) begin
      for (int g = 0; g < 3; g++) begin
        msk[g] = 8'($random(seed));
        wr(8'(irq_unit_pkg::OFS_GROUP0_MASK + g), msk[g]);
      end
      en = 8'($random(seed));
      wr(irq_unit_pkg::OFS_GROUP_CTRL, en);
      global_irq_enable = 1'($random(seed));
      oldc = chg_target;
      chg_target = 24'($random(seed));
      settle();
      gexp = grp(oldc ^ chg_target);
      rd(irq_unit_pkg::OFS_GROUP_FLAGS, rdv);
      chk(rdv, {5'h00, gexp});
      chk(irq_request[4:2], gexp & en[2:0] & {3{global_irq_enable}});
      if (i[0]) wr(irq_unit_pkg::OFS_GROUP_FLAGS, 8'h07);
      else ack(5'h1C);
      rd(irq_unit_pkg::OFS_GROUP_FLAGS, rdv);
      chk(rdv, 8'h00);
    end
    stop_test();
  end
endmodule
